// ==== src/ari_pkg.sv ====
// Purpose: shared constants for the alarm, reset and interface-select block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses

package ari_pkg;

   // ************************************************
   // sizes
   // ************************************************
   localparam int unsigned NUM_CH      = 4;
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned TEMP_W      = 8;

   // ************************************************
   // register offsets
   // ************************************************
   localparam logic [7:0] SYS_CTRL_OFS   = 8'h00;
   localparam logic [7:0] ALARM_STAT_OFS = 8'h04;
   localparam logic [7:0] STRAP_STAT_OFS = 8'h08;
   localparam logic [7:0] MU_BASE_OFS    = 8'h10;
   localparam logic [7:0] MU_LAST_OFS    = 8'h1C;

   // ************************************************
   // system control fields
   // ************************************************
   localparam int unsigned CG_EN_BIT     = 0;
   localparam int unsigned CG_LATCH_BIT  = 1;
   localparam int unsigned GUARD_EN_BIT  = 2;
   localparam int unsigned CLAMP_EN_BIT  = 3;
   localparam int unsigned CMP_KEEP_BIT  = 4;
   localparam int unsigned LIMIT_LSB     = 8;
   localparam int unsigned LSENSE_LSB    = 16;

   // ************************************************
   // alarm status fields
   // ************************************************
   localparam int unsigned TEMP_LAT_BIT  = 0;
   localparam int unsigned TEMP_LIVE_BIT = 1;
   localparam int unsigned CH_STAT_LSB   = 4;
   localparam int unsigned CH_STAT_W     = 4;

   // ************************************************
   // per-channel unit register fields
   // ************************************************
   localparam int unsigned MU_CLR_BIT    = 6;
   localparam int unsigned MU_CFG_W      = 16;

   // ************************************************
   // reset values and strap wait count
   // ************************************************
   localparam logic [TEMP_W-1:0]   TEMP_LIMIT_DFLT = 8'h82;  // 130 degrees
   localparam logic [31:0]         SYS_CTRL_RST    = 32'h0000_8200;
   localparam logic [MU_CFG_W-1:0] MU_CFG_RST      = 16'h0000;
   localparam logic [1:0]          STRAP_WAIT      = 2'h2;

endpackage

// ==== src/ari_sync.sv ====
// Purpose: two-flop synchroniser bank for pin-level inputs
// Assumes: inputs are slow levels, not buses needing coherence
// Notes:   first stage is read only by the second

`timescale 1ns/1ps

module ari_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d,
   output      logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_ff;

   if (WIDTH == 0) begin : g_width_chk
      $error("ari_sync: WIDTH must be at least one");
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule

// ==== src/ari_top.sv ====
// Purpose: alarm outputs, interface strap and low-sense routing behind APB
// Assumes: fault and strap inputs are pin levels; temp_code is on clk
// Notes:   zero-wait APB slave, answer one cycle after setup

`timescale 1ns/1ps

module ari_top
   import ari_pkg::*;
#(
   parameter int unsigned CH = ari_pkg::NUM_CH
) (
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [ari_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output      logic [31:0]               prdata,
   output      logic                      pready,
   output      logic                      pslverr,
   input  wire logic [ari_pkg::TEMP_W-1:0] temp_code,
   input  wire logic [CH-1:0]             guard_fault,
   input  wire logic [CH-1:0]             clamp_fault,
   input  wire logic                      if_select_strap,
   output      logic                      over_temp_alarm_n_o,
   output      logic                      over_temp_alarm_oe_n,
   output      logic                      guard_clamp_alarm_n_o,
   output      logic                      guard_clamp_alarm_oe_n,
   output      logic                      diff_if_sel,
   output      logic                      cmp_pins_diff,
   output      logic [CH-1:0]             low_sense_private,
   output      logic [CH-1:0]             guard_from_high_sense
);
   import ari_pkg::*;

   if (CH == 0 || CH > NUM_CH) begin : g_ch_chk
      $error("ari_top: CH must be 1 to 4");
   end

   // ************************************************
   // pin synchronisers
   // ************************************************
   logic [CH-1:0] guard_s;
   logic [CH-1:0] clamp_s;
   logic          strap_s;

   ari_sync #(.WIDTH(2*CH+1)) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({if_select_strap, clamp_fault, guard_fault}),
      .q     ({strap_s, clamp_s, guard_s})
   );

   // ************************************************
   // bus decode
   // ************************************************
   function automatic logic is_mu(input logic [ADDR_W-1:0] a);
      return (a >= MU_BASE_OFS) && (a <= MU_LAST_OFS) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == SYS_CTRL_OFS) || (a == ALARM_STAT_OFS) ||
             (a == STRAP_STAT_OFS) || is_mu(a);
   endfunction

   logic setup_c;
   logic access_c;
   logic wr_c;
   logic clr_c;

   assign setup_c  = psel && !penable;
   assign access_c = psel && penable && pready;
   assign wr_c     = access_c && pwrite && is_mapped(paddr);
   assign clr_c    = wr_c && is_mu(paddr) && pwdata[MU_CLR_BIT];

   // ************************************************
   // control registers
   // ************************************************
   logic [31:0]         sys_ctrl_ff;
   logic [MU_CFG_W-1:0] mu_cfg_ff [CH];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_ctrl_ff <= SYS_CTRL_RST;
      end else if (wr_c && paddr == SYS_CTRL_OFS) begin
         sys_ctrl_ff <= pwdata;
      end
   end

   // clear bit is a strobe, not stored
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < CH; i++) begin
            mu_cfg_ff[i] <= MU_CFG_RST;
         end
      end else if (wr_c && is_mu(paddr)) begin
         for (int i = 0; i < CH; i++) begin
            if (paddr[3:2] == 2'(i)) begin
               mu_cfg_ff[i] <= pwdata[MU_CFG_W-1:0] & ~(16'h0001 << MU_CLR_BIT);
            end
         end
      end
   end

   logic                cg_en;
   logic                cg_latch;
   logic                guard_en;
   logic                clamp_en;
   logic [TEMP_W-1:0]   temp_limit;

   assign cg_en      = sys_ctrl_ff[CG_EN_BIT];
   assign cg_latch   = sys_ctrl_ff[CG_LATCH_BIT];
   assign guard_en   = sys_ctrl_ff[GUARD_EN_BIT];
   assign clamp_en   = sys_ctrl_ff[CLAMP_EN_BIT];
   assign temp_limit = sys_ctrl_ff[LIMIT_LSB +: TEMP_W];

   // ************************************************
   // temperature alarm
   // ************************************************
   logic temp_over_c;
   logic temp_live_c;
   logic temp_lat_ff;

   assign temp_over_c = temp_code > temp_limit;
   assign temp_live_c = temp_code > TEMP_LIMIT_DFLT;

   // set beats clear so a fresh event is never lost
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         temp_lat_ff <= 1'b0;
      end else begin
         temp_lat_ff <= (temp_lat_ff && !clr_c) || temp_over_c;
      end
   end

   // ************************************************
   // guard and clamp alarms
   // ************************************************
   logic [CH-1:0] guard_lat_ff;
   logic [CH-1:0] clamp_lat_ff;
   logic          cg_lat_ff;
   logic          cg_live_c;

   assign cg_live_c = (guard_en && |guard_s) || (clamp_en && |clamp_s);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         guard_lat_ff <= '0;
         clamp_lat_ff <= '0;
      end else begin
         guard_lat_ff <= (guard_lat_ff & {CH{!clr_c}}) | guard_s;
         clamp_lat_ff <= (clamp_lat_ff & {CH{!clr_c}}) | clamp_s;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cg_lat_ff <= 1'b0;
      end else begin
         cg_lat_ff <= (cg_lat_ff && !clr_c) || (cg_en && cg_live_c);
      end
   end

   // ************************************************
   // open-drain outputs, enable low means pulled low
   // ************************************************
   logic cg_act_c;

   assign cg_act_c = cg_en && (cg_latch ? cg_lat_ff : cg_live_c);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         over_temp_alarm_n_o    <= 1'b0;
         over_temp_alarm_oe_n   <= 1'b1;
         guard_clamp_alarm_n_o  <= 1'b0;
         guard_clamp_alarm_oe_n <= 1'b1;
      end else begin
         over_temp_alarm_n_o    <= 1'b0;
         over_temp_alarm_oe_n   <= !(temp_lat_ff || temp_over_c);
         guard_clamp_alarm_n_o  <= 1'b0;
         guard_clamp_alarm_oe_n <= !cg_act_c;
      end
   end

   // ************************************************
   // strap capture after reset release
   // ************************************************
   // the synchroniser needs two edges to show the pin, so wait for it
   logic [1:0] strap_wait_ff;
   logic       strap_done_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_wait_ff <= '0;
         strap_done_ff <= 1'b0;
         diff_if_sel   <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_wait_ff <= strap_wait_ff + 2'h1;
         if (strap_wait_ff == STRAP_WAIT) begin
            strap_done_ff <= 1'b1;
            diff_if_sel   <= strap_s;
         end
      end
   end

   // ************************************************
   // pin role and low-sense routing
   // ************************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmp_pins_diff         <= 1'b0;
         low_sense_private     <= '0;
         guard_from_high_sense <= '0;
      end else begin
         cmp_pins_diff         <= diff_if_sel && !sys_ctrl_ff[CMP_KEEP_BIT];
         low_sense_private     <= sys_ctrl_ff[LSENSE_LSB +: CH];
         guard_from_high_sense <= sys_ctrl_ff[LSENSE_LSB +: CH];
      end
   end

   // ************************************************
   // read path
   // ************************************************
   logic [31:0] stat_c;
   logic [31:0] rd_c;

   always_comb begin
      stat_c = '0;
      stat_c[TEMP_LAT_BIT]  = temp_lat_ff;
      stat_c[TEMP_LIVE_BIT] = temp_live_c;
      for (int i = 0; i < CH; i++) begin
         stat_c[CH_STAT_LSB + CH_STAT_W*i +: CH_STAT_W] =
            {clamp_s[i], clamp_lat_ff[i], guard_s[i], guard_lat_ff[i]};
      end
   end

   always_comb begin
      rd_c = '0;
      if (paddr == SYS_CTRL_OFS) begin
         rd_c = sys_ctrl_ff;
      end else if (paddr == ALARM_STAT_OFS) begin
         rd_c = stat_c;
      end else if (paddr == STRAP_STAT_OFS) begin
         rd_c = {30'h0, cmp_pins_diff, diff_if_sel};
      end else if (is_mu(paddr)) begin
         for (int i = 0; i < CH; i++) begin
            if (paddr[3:2] == 2'(i)) begin
               rd_c = {16'h0000, mu_cfg_ff[i]};
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup_c;
         pslverr <= setup_c && !is_mapped(paddr);
         if (setup_c && !pwrite) begin
            prdata <= rd_c;
         end
      end
   end

   // ************************************************
   // checks
   // ************************************************
   sequence s_clear;
      clr_c && !temp_over_c;
   endsequence

   sequence s_temp_event;
      temp_over_c;
   endsequence

   a_temp_drive_low: assert property (@(posedge clk) disable iff (!rst_b)
      s_temp_event |=> !over_temp_alarm_oe_n && !over_temp_alarm_n_o)
      else $error("over-temperature alarm not driven");

   a_temp_latch_hold: assert property (@(posedge clk) disable iff (!rst_b)
      temp_lat_ff && !clr_c |=> temp_lat_ff)
      else $error("temperature latch dropped without clear");

   a_temp_clear_works: assert property (@(posedge clk) disable iff (!rst_b)
      s_clear ##1 !temp_over_c |=> over_temp_alarm_oe_n)
      else $error("temperature alarm not released");

   a_temp_live_flag: assert property (@(posedge clk) disable iff (!rst_b)
      !pwrite && setup_c && paddr == ALARM_STAT_OFS |=>
         prdata[TEMP_LIVE_BIT] == $past(temp_code > 8'h82))
      else $error("live temperature flag wrong");

   a_cg_off_default: assert property (@(posedge clk) disable iff (!rst_b)
      !cg_en |=> guard_clamp_alarm_oe_n)
      else $error("guard/clamp alarm active while disabled");

   a_cg_live_mode: assert property (@(posedge clk) disable iff (!rst_b)
      cg_en && !cg_latch && !cg_live_c |=> guard_clamp_alarm_oe_n)
      else $error("live mode output held");

   a_cg_latch_mode: assert property (@(posedge clk) disable iff (!rst_b)
      cg_en && cg_latch && cg_lat_ff && !clr_c ##1 cg_en && cg_latch
         |=> !guard_clamp_alarm_oe_n)
      else $error("latched guard/clamp alarm released early");

   a_src_disable: assert property (@(posedge clk) disable iff (!rst_b)
      cg_en && !guard_en && !clamp_en && !cg_latch |=> guard_clamp_alarm_oe_n)
      else $error("disabled sources drove alarm");

   a_chan_latch: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> &(guard_lat_ff | ~$past(guard_s)) && &(clamp_lat_ff | ~$past(clamp_s)))
      else $error("alarm source flag not latched");

   a_cmp_role: assert property (@(posedge clk) disable iff (!rst_b)
      diff_if_sel && !sys_ctrl_ff[CMP_KEEP_BIT] |=> cmp_pins_diff)
      else $error("comparator pins not given to interface");

   a_lsense_route: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> low_sense_private == $past(sys_ctrl_ff[LSENSE_LSB +: CH]) &&
         guard_from_high_sense == low_sense_private)
      else $error("low-sense and guard routing disagree");

endmodule

// ==== verif/ari_host.sv ====
// Purpose: host-side partner: apb master and pull-ups on both open-drain alarm lines
// Assumes: slave answers with pready; level changes only right after a rising edge
// Notes:   tasks are called hierarchically by the bench

`timescale 1ns/1ps

module ari_host
   import ari_pkg::*;
(
   input  wire logic                       clk,
   output      logic                       psel,
   output      logic                       penable,
   output      logic                       pwrite,
   output      logic [ari_pkg::ADDR_W-1:0] paddr,
   output      logic [31:0]                pwdata,
   input  wire logic [31:0]                prdata,
   input  wire logic                       pready,
   input  wire logic                       pslverr,
   input  wire logic                       tmp_n_o,
   input  wire logic                       tmp_oe_n,
   input  wire logic                       gc_n_o,
   input  wire logic                       gc_oe_n,
   output      logic                       tmp_lvl,
   output      logic                       gc_lvl
);
   // ************************************************
   // wire levels
   // ************************************************
   // board pull-ups: a released line reads high
   assign tmp_lvl = tmp_oe_n ? 1'b1 : tmp_n_o;
   assign gc_lvl  = gc_oe_n ? 1'b1 : gc_n_o;

   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = '0;
   end

   // ************************************************
   // bus cycles
   // ************************************************
   // one idle edge first so a strobe is never driven twice in one step
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // no cycle count assumed: only the bench watchdog ends a stuck wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic apb_write(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] rd;
      logic        err;
      xfer(1'b1, a, wd, rd, err);
   endtask

   task automatic apb_read(input logic [7:0] a, output logic [31:0] rd, output logic err);
      xfer(1'b0, a, 32'h0000_0000, rd, err);
   endtask

   // host clears latched alarms by a one in bit 6 of a unit register
   task automatic clear_alarms(input int ch);
      apb_write(MU_BASE_OFS + 8'(4 * ch), 32'h0000_0040);
   endtask
endmodule

// ==== verif/ari_top_bench.sv ====
// Purpose: self-checking bench for the alarm, reset and interface-select block
// Assumes: host partner drives apb; bench drives pins and temperature code
// Notes:   fault inputs pass a 2-flop sync, so settle waits cover that latency

`timescale 1ns/1ps

module ari_top_bench;
   import ari_pkg::*;

   // ************************************************
   // signals
   // ************************************************
   logic                clk;
   logic                rst_b;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [ADDR_W-1:0]   paddr;
   logic [31:0]         pwdata;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic [TEMP_W-1:0]   temp_code;
   logic [NUM_CH-1:0]   guard_fault;
   logic [NUM_CH-1:0]   clamp_fault;
   logic                if_select_strap;
   logic                tmp_n_o;
   logic                tmp_oe_n;
   logic                gc_n_o;
   logic                gc_oe_n;
   logic                diff_if_sel;
   logic                cmp_pins_diff;
   logic [NUM_CH-1:0]   low_sense_private;
   logic [NUM_CH-1:0]   guard_from_high_sense;
   logic                tmp_lvl;
   logic                gc_lvl;
   logic [31:0]         rd;
   logic                err;
   int                  n_errors;
   int                  total_checks;

   ari_top u_dut (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .temp_code(temp_code), .guard_fault(guard_fault),
      .clamp_fault(clamp_fault), .if_select_strap(if_select_strap),
      .over_temp_alarm_n_o(tmp_n_o), .over_temp_alarm_oe_n(tmp_oe_n),
      .guard_clamp_alarm_n_o(gc_n_o), .guard_clamp_alarm_oe_n(gc_oe_n),
      .diff_if_sel(diff_if_sel), .cmp_pins_diff(cmp_pins_diff),
      .low_sense_private(low_sense_private), .guard_from_high_sense(guard_from_high_sense)
   );

   ari_host u_host (
      .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tmp_n_o(tmp_n_o), .tmp_oe_n(tmp_oe_n), .gc_n_o(gc_n_o), .gc_oe_n(gc_oe_n),
      .tmp_lvl(tmp_lvl), .gc_lvl(gc_lvl)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ************************************************
   // helpers
   // ************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      u_host.apb_read(a, rd, err);
      chk(rd, exp);
      chk({31'h0, err}, 32'h0);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // board holds the strap steady across the whole reset
   task automatic do_reset(input logic strap);
      if_select_strap <= strap;
      rst_b           <= 1'b0;
      idle(5);
      rst_b           <= 1'b1;
      idle(6);
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #100us;
      n_errors++;
      complete_run;
   end

   // ************************************************
   // tests
   // ************************************************
   initial begin
      n_errors = 0;
      total_checks = 0;
      rst_b = 1'b0;
      temp_code = 8'h14;
      guard_fault = 4'h0;
      clamp_fault = 4'h0;
      if_select_strap = 1'b1;
      @(posedge clk);
      do_reset(1'b1);
      rchk(SYS_CTRL_OFS, SYS_CTRL_RST);
      rchk(ALARM_STAT_OFS, 32'h0);
      rchk(STRAP_STAT_OFS, 32'h3);
      chk({31'h0, cmp_pins_diff}, 32'h1);
      chk({28'h0, low_sense_private}, 32'h0);
      chk({28'h0, guard_from_high_sense}, 32'h0);
      // temperature above default limit, then back to the limit itself
      temp_code <= 8'h83;
      idle(4);
      chk({31'h0, tmp_lvl}, 32'h0);
      rchk(ALARM_STAT_OFS, 32'h3);
      temp_code <= 8'h82;
      idle(4);
      chk({31'h0, tmp_lvl}, 32'h0);
      rchk(ALARM_STAT_OFS, 32'h1);
      u_host.clear_alarms(3);
      idle(3);
      chk({31'h0, tmp_lvl}, 32'h1);
      rchk(ALARM_STAT_OFS, 32'h0);
      // programmed limit below the fixed live threshold
      u_host.apb_write(SYS_CTRL_OFS, 32'h0000_6400);
      temp_code <= 8'h6E;
      idle(4);
      chk({31'h0, tmp_lvl}, 32'h0);
      rchk(ALARM_STAT_OFS, 32'h1);
      temp_code <= 8'h14;
      u_host.clear_alarms(0);
      idle(3);
      chk({31'h0, tmp_lvl}, 32'h1);
      // guard and clamp sources
      u_host.apb_write(SYS_CTRL_OFS, SYS_CTRL_RST);
      guard_fault <= 4'h2;
      idle(5);
      chk({31'h0, gc_lvl}, 32'h1);
      rchk(ALARM_STAT_OFS, 32'h0000_0300);
      // output enabled but both sources off: must stay released
      u_host.apb_write(SYS_CTRL_OFS, 32'h0000_8201);
      idle(3);
      chk({31'h0, gc_lvl}, 32'h1);
      u_host.apb_write(SYS_CTRL_OFS, 32'h0000_8205);
      idle(3);
      chk({31'h0, gc_lvl}, 32'h0);
      guard_fault <= 4'h0;
      idle(5);
      chk({31'h0, gc_lvl}, 32'h1);
      rchk(ALARM_STAT_OFS, 32'h0000_0100);
      clamp_fault <= 4'h8;
      idle(5);
      chk({31'h0, gc_lvl}, 32'h1);
      u_host.apb_write(SYS_CTRL_OFS, 32'h0000_820D);
      idle(3);
      chk({31'h0, gc_lvl}, 32'h0);
      rchk(ALARM_STAT_OFS, 32'h000C_0100);
      u_host.apb_write(SYS_CTRL_OFS, 32'h0000_820B);
      idle(3);
      clamp_fault <= 4'h0;
      idle(5);
      chk({31'h0, gc_lvl}, 32'h0);
      u_host.clear_alarms(1);
      idle(3);
      chk({31'h0, gc_lvl}, 32'h1);
      rchk(ALARM_STAT_OFS, 32'h0);
      // per-channel private low sense
      // keep bit set too: comparator pins go back to comparators
      u_host.apb_write(SYS_CTRL_OFS, 32'h000A_8210);
      idle(3);
      chk({28'h0, low_sense_private}, 32'hA);
      chk({28'h0, guard_from_high_sense}, 32'hA);
      chk({31'h0, cmp_pins_diff}, 32'h0);
      rchk(STRAP_STAT_OFS, 32'h1);
      // unit register keeps its bits but never stores the clear bit
      u_host.apb_write(MU_BASE_OFS + 8'h08, 32'h0000_12C5);
      rchk(MU_BASE_OFS + 8'h08, 32'h0000_1285);
      // status is read-only, unmapped place refused
      u_host.apb_write(ALARM_STAT_OFS, 32'hFFFF_FFFF);
      rchk(ALARM_STAT_OFS, 32'h0);
      u_host.apb_read(8'h40, rd, err);
      chk({31'h0, err}, 32'h1);
      // mid-run reset with the strap low
      do_reset(1'b0);
      rchk(SYS_CTRL_OFS, SYS_CTRL_RST);
      rchk(STRAP_STAT_OFS, 32'h0);
      chk({31'h0, diff_if_sel}, 32'h0);
      chk({28'h0, low_sense_private}, 32'h0);
      rchk(MU_BASE_OFS + 8'h08, 32'h0);
      complete_run;
   end
endmodule
